// ---- design/fan_pkg.sv ----
package fan_pkg;

  localparam int          LEVEL_W         = 8;
  localparam logic [7:0]  PWM_MIN_CODE    = 8'h4d;
  localparam logic [7:0]  PWM_MAX_CODE    = 8'hb3;
  localparam logic [7:0]  PWM_TOP_CODE    = PWM_MAX_CODE - 8'h01;
  localparam logic [7:0]  RAMP_STEP       = 8'h01;

  localparam int          CLK_HZ          = 25_000_000;
  localparam int          PWM_HZ          = 60;
  localparam int          PERIOD_CYCLES   = CLK_HZ / PWM_HZ;
  localparam int          RAMP_STEPS      =
    2 * (int'(PWM_TOP_CODE) - int'(PWM_MIN_CODE));
  localparam int          STEP_CYCLES_DEF = PERIOD_CYCLES / RAMP_STEPS;
  localparam int          STEP_W          = 12;

  localparam int          START_W         = 6;
  localparam logic [5:0]  START_LAST      = 6'h3f;
  localparam logic [5:0]  START_INC       = 6'h01;

  localparam int          FLAG_W          = 6;
  localparam int          F_RESTART       = 0;
  localparam int          F_OVERTEMP      = 1;
  localparam int          F_P_SLEEP       = 2;
  localparam int          F_S_SLEEP       = 3;
  localparam int          F_P_WAKE        = 4;
  localparam int          F_S_WAKE        = 5;

  localparam logic        FAN_ON          = 1'b1;
  localparam logic        FAN_OFF         = 1'b0;
  localparam logic        PIN_DRIVE       = 1'b0;
  localparam logic        PIN_FLOAT       = 1'b1;
  localparam logic        FAULT_ACTIVE    = 1'b0;
  localparam logic        FAULT_IDLE      = 1'b1;

  typedef enum logic [2:0] {
    ST_WAIT_WAKE,
    ST_STARTUP,
    ST_RUN,
    ST_SLEEP,
    ST_SHUTDOWN
  } fan_state_t;

endpackage

// ---- design/ramp_if.sv ----
`timescale 1ns/10ps
`default_nettype none

interface ramp_if;
  import fan_pkg::*;

  logic               ce;
  logic [LEVEL_W-1:0] ramp;
  logic               tick;

  modport src (input ce, output ramp, output tick);
  modport snk (output ce, input ramp, input tick);
endinterface

`default_nettype wire

// ---- design/pwm_ramp.sv ----
`timescale 1ns/10ps
`default_nettype none

module pwm_ramp
  import fan_pkg::*;
#(
  parameter int STEP_CYCLES = STEP_CYCLES_DEF
)
(
  input  wire logic clk,
  input  wire logic rst,
  ramp_if.src       rb
);

  typedef struct packed {
    logic [STEP_W-1:0]  div;
    logic [LEVEL_W-1:0] ramp;
    logic               up;
    logic               tick;
  } ramp_rec_t;

  localparam ramp_rec_t RAMP_RESET = '{
    div:  '0,
    ramp: PWM_MIN_CODE,
    up:   1'b1,
    tick: 1'b0
  };

  ramp_rec_t s_reg;
  ramp_rec_t s_next;

  ////////////////////////////////////////////////////////////////////////////
  // Triangle ramp; one full triangle is one time-base period
  always_comb
  begin
    s_next = s_reg;
    if (rb.ce)
    begin
      s_next.tick = 1'b0;
      if (s_reg.div == STEP_W'(STEP_CYCLES - 1))
      begin
        s_next.div = '0;
        if (s_reg.up)
        begin
          if (s_reg.ramp == PWM_TOP_CODE)
          begin
            s_next.up   = 1'b0;
            s_next.ramp = s_reg.ramp - RAMP_STEP;
          end
          else
            s_next.ramp = s_reg.ramp + RAMP_STEP;
        end
        else if (s_reg.ramp == PWM_MIN_CODE)
        begin
          s_next.up   = 1'b1;
          s_next.ramp = s_reg.ramp + RAMP_STEP;
          s_next.tick = 1'b1;
        end
        else
          s_next.ramp = s_reg.ramp - RAMP_STEP;
      end
      else
        s_next.div = s_reg.div + STEP_W'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_reg <= RAMP_RESET;
    else
      s_reg <= s_next;
  end

  assign rb.ramp = s_reg.ramp;
  assign rb.tick = s_reg.tick;

  ////////////////////////////////////////////////////////////////////////////
  a_ramp_span: assert property (
    @(posedge clk) disable iff (rst)
    (rb.ramp >= PWM_MIN_CODE) && (rb.ramp <= PWM_TOP_CODE))
    else $error("ramp left its span");

  a_tick_turn: assert property (
    @(posedge clk) disable iff (rst)
    rb.tick |-> s_reg.up && (rb.ramp > PWM_MIN_CODE))
    else $error("period tick not at ramp bottom");

endmodule

`default_nettype wire

// ---- design/fan_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none

module fan_ctrl
  import fan_pkg::*;
#(
  parameter int STEP_CYCLES = STEP_CYCLES_DEF
)
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire logic               shutdown_flag,
  input  wire logic               restart_flag,
  input  wire logic               overtemp_flag,
  input  wire logic               primary_below_sleep,
  input  wire logic               secondary_below_sleep,
  input  wire logic               primary_above_wake,
  input  wire logic               secondary_above_wake,
  input  wire logic [LEVEL_W-1:0] primary_control_input,
  input  wire logic [LEVEL_W-1:0] secondary_control_input,
  output var  logic               fan_out,
  output var  logic               fan_oe_n,
  output var  logic               overtemp_fault_n,
  output var  logic               fault_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // State record
  typedef struct packed {
    logic [FLAG_W-1:0]  flags_s1;
    logic [FLAG_W-1:0]  flags_s2;
    logic [LEVEL_W-1:0] prim_s1;
    logic [LEVEL_W-1:0] prim_s2;
    logic [LEVEL_W-1:0] sec_s1;
    logic [LEVEL_W-1:0] sec_s2;
    fan_state_t         state;
    logic [START_W-1:0] start_cnt;
    logic               fan;
    logic               fan_oe_n;
    logic               fault_n;
    logic               fault_oe_n;
  } fan_rec_t;

  localparam fan_rec_t POWERUP_REC = '{
    flags_s1:   '0,
    flags_s2:   '0,
    prim_s1:    '0,
    prim_s2:    '0,
    sec_s1:     '0,
    sec_s2:     '0,
    state:      ST_WAIT_WAKE,
    start_cnt:  '0,
    fan:        FAN_OFF,
    fan_oe_n:   PIN_DRIVE,
    fault_n:    FAULT_IDLE,
    fault_oe_n: PIN_FLOAT
  };

  localparam fan_rec_t SHUTDOWN_REC = '{
    flags_s1:   '0,
    flags_s2:   '0,
    prim_s1:    '0,
    prim_s2:    '0,
    sec_s1:     '0,
    sec_s2:     '0,
    state:      ST_SHUTDOWN,
    start_cnt:  '0,
    fan:        FAN_OFF,
    fan_oe_n:   PIN_FLOAT,
    fault_n:    FAULT_IDLE,
    fault_oe_n: PIN_FLOAT
  };

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [LEVEL_W-1:0] max_level(
    input logic [LEVEL_W-1:0] a,
    input logic [LEVEL_W-1:0] b
  );
    max_level = (a > b) ? a : b;
  endfunction

  function automatic logic either_flag(
    input logic [FLAG_W-1:0] f,
    input int                i,
    input int                j
  );
    either_flag = f[i] | f[j];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Time base
  ramp_if rb ();

  assign rb.ce = ce;

  pwm_ramp #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_ramp (
    .clk (clk),
    .rst (rst),
    .rb  (rb)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  fan_rec_t           s_reg;
  fan_rec_t           s_next;
  logic [LEVEL_W-1:0] duty_level;
  logic               pwm_high;
  logic               wake_any;
  logic               sleep_both;
  logic               overtemp_s;

  always_comb
  begin
    duty_level = max_level(s_reg.prim_s2, s_reg.sec_s2);
    pwm_high   = duty_level > rb.ramp;
    wake_any   = either_flag(s_reg.flags_s2, F_P_WAKE, F_S_WAKE);
    sleep_both = s_reg.flags_s2[F_P_SLEEP] & s_reg.flags_s2[F_S_SLEEP];
    overtemp_s = s_reg.flags_s2[F_OVERTEMP];
  end

  always_comb
  begin
    s_next = s_reg;
    if (ce)
    begin
      s_next.flags_s1 = {secondary_above_wake, primary_above_wake,
                         secondary_below_sleep, primary_below_sleep,
                         overtemp_flag, restart_flag};
      s_next.flags_s2 = s_reg.flags_s1;
      s_next.prim_s1  = primary_control_input;
      s_next.prim_s2  = s_reg.prim_s1;
      s_next.sec_s1   = secondary_control_input;
      s_next.sec_s2   = s_reg.sec_s1;

      case (s_reg.state)
        ST_WAIT_WAKE:
        begin
          s_next.fan      = FAN_OFF;
          s_next.fan_oe_n = PIN_DRIVE;
          if (rb.tick && wake_any)
          begin
            s_next.state     = ST_STARTUP;
            s_next.start_cnt = '0;
          end
        end
        ST_STARTUP:
        begin
          s_next.fan      = FAN_ON;
          s_next.fan_oe_n = PIN_DRIVE;
          if (rb.tick)
          begin
            if (s_reg.start_cnt == START_LAST)
              s_next.state = ST_RUN;
            else
              s_next.start_cnt = s_reg.start_cnt + START_INC;
          end
        end
        ST_RUN:
        begin
          s_next.fan      = pwm_high;
          s_next.fan_oe_n = PIN_DRIVE;
          if (rb.tick && sleep_both)
            s_next.state = ST_SLEEP;
        end
        ST_SLEEP:
        begin
          s_next.fan      = FAN_OFF;
          s_next.fan_oe_n = PIN_FLOAT;
          if (rb.tick && wake_any)
          begin
            s_next.state     = ST_STARTUP;
            s_next.start_cnt = '0;
          end
        end
        ST_SHUTDOWN:
        begin
          s_next.fan      = FAN_OFF;
          s_next.fan_oe_n = PIN_FLOAT;
          if (rb.tick && s_reg.flags_s2[F_RESTART])
            s_next = POWERUP_REC;
        end
        default:
          s_next = POWERUP_REC;
      endcase

      if ((s_next.state == ST_SLEEP) || (s_next.state == ST_SHUTDOWN))
      begin
        s_next.fault_n    = FAULT_IDLE;
        s_next.fault_oe_n = PIN_FLOAT;
      end
      else if (rb.tick && (s_reg.state != ST_SHUTDOWN))
      begin
        s_next.fault_n    = overtemp_s ? FAULT_ACTIVE
                                       : FAULT_IDLE;
        s_next.fault_oe_n = overtemp_s ? PIN_DRIVE : PIN_FLOAT;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register; shutdown clears at once and outranks everything
  always_ff @(posedge clk or posedge shutdown_flag)
  begin
    if (shutdown_flag)
      s_reg <= SHUTDOWN_REC;
    else if (rst)
      s_reg <= POWERUP_REC;
    else
      s_reg <= s_next;
  end

  assign fan_out          = s_reg.fan;
  assign fan_oe_n         = s_reg.fan_oe_n;
  assign overtemp_fault_n = s_reg.fault_n;
  assign fault_oe_n       = s_reg.fault_oe_n;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_shutdown_float: assert property (
    @(posedge clk) disable iff (rst)
    (shutdown_flag && $past(shutdown_flag))
      |-> (fan_oe_n == PIN_FLOAT) && (fault_oe_n == PIN_FLOAT)
          && (overtemp_fault_n == FAULT_IDLE))
    else $error("outputs not released in shutdown");

  a_poweron_state: assert property (
    @(posedge clk) disable iff (shutdown_flag)
    rst |=> (fan_out == FAN_OFF) && (fan_oe_n == PIN_DRIVE)
            && (overtemp_fault_n == FAULT_IDLE)
            && (s_reg.state == ST_WAIT_WAKE))
    else $error("wrong state after reset");

  a_wait_gate: assert property (
    @(posedge clk) disable iff (rst || shutdown_flag)
    (ce && (s_reg.state == ST_WAIT_WAKE) && !wake_any)
      |=> (s_reg.state == ST_WAIT_WAKE))
    else $error("fan started without wake");

  a_startup_drive: assert property (
    @(posedge clk) disable iff (rst || shutdown_flag)
    (ce && (s_reg.state == ST_STARTUP))
      |=> (fan_out == FAN_ON) && (fan_oe_n == PIN_DRIVE))
    else $error("fan not forced on during startup");

  a_startup_len: assert property (
    @(posedge clk) disable iff (rst || shutdown_flag)
    (ce && rb.tick && (s_reg.state == ST_STARTUP))
      |=> (s_reg.state == (($past(s_reg.start_cnt) == START_LAST) ? ST_RUN
                                                                  : ST_STARTUP))
          && ($past(s_reg.start_cnt) == START_LAST
              || s_reg.start_cnt == $past(s_reg.start_cnt) + START_INC))
    else $error("startup interval miscounted");

  a_startup_entry: assert property (
    @(posedge clk) disable iff (rst || shutdown_flag)
    (ce && rb.tick && wake_any && (s_reg.state == ST_SLEEP))
      |=> (s_reg.state == ST_STARTUP) && (s_reg.start_cnt == '0))
    else $error("wake did not restart the startup interval");

  a_pwm_compare: assert property (
    @(posedge clk) disable iff (rst || shutdown_flag)
    (ce && (s_reg.state == ST_RUN))
      |=> (fan_out == ($past(max_level(s_reg.prim_s2, s_reg.sec_s2))
                        > $past(rb.ramp))))
    else $error("pwm output disagrees with ramp");

  a_fault_follow: assert property (
    @(posedge clk) disable iff (rst || shutdown_flag)
    (ce && rb.tick && (s_reg.state == ST_RUN) && !sleep_both)
      |=> (overtemp_fault_n == !$past(overtemp_s))
          && (fault_oe_n == overtemp_fault_n))
    else $error("fault output does not follow overtemperature");

  a_sleep_entry: assert property (
    @(posedge clk) disable iff (rst || shutdown_flag)
    (ce && rb.tick && sleep_both && (s_reg.state == ST_RUN))
      |=> (s_reg.state == ST_SLEEP) && (overtemp_fault_n == FAULT_IDLE)
      ##1 (fan_oe_n == PIN_FLOAT) || !$past(ce))
    else $error("sleep not entered or outputs not released");

  a_sleep_hold: assert property (
    @(posedge clk) disable iff (rst || shutdown_flag)
    ((s_reg.state == ST_SLEEP) && !wake_any)
      |=> (s_reg.state == ST_SLEEP))
    else $error("sleep left without wake");

  a_run_drive: assert property (
    @(posedge clk) disable iff (rst || shutdown_flag)
    (ce && (s_reg.state == ST_RUN)) |=> (fan_oe_n == PIN_DRIVE))
    else $error("fan pin not driven while running");

  a_wake_start: assert property (
    @(posedge clk) disable iff (rst || shutdown_flag)
    (ce && rb.tick && wake_any && (s_reg.state == ST_WAIT_WAKE))
      |=> (s_reg.state == ST_STARTUP) && (s_reg.start_cnt == '0))
    else $error("wake did not start the fan");

  a_restart_reset: assert property (
    @(posedge clk) disable iff (rst || shutdown_flag)
    (ce && rb.tick && s_reg.flags_s2[F_RESTART]
      && (s_reg.state == ST_SHUTDOWN))
      |=> (s_reg.state == ST_WAIT_WAKE) && (fault_oe_n == PIN_FLOAT)
          && (fan_oe_n == PIN_DRIVE))
    else $error("restart did not act as power-up");

  a_sleep_quiet: assert property (
    @(posedge clk) disable iff (rst)
    (s_reg.state == ST_SLEEP)
      |-> (overtemp_fault_n == FAULT_IDLE) && (fault_oe_n == PIN_FLOAT))
    else $error("fault active while asleep");

  a_shutdown_hold: assert property (
    @(posedge clk) disable iff (rst)
    ((s_reg.state == ST_SHUTDOWN)
      && !(ce && rb.tick && s_reg.flags_s2[F_RESTART]))
      |=> (s_reg.state == ST_SHUTDOWN))
    else $error("shutdown left without restart");

endmodule

`default_nettype wire

// ---- sim/fan_far_side.sv ----
`timescale 1ns/10ps
`default_nettype none

module fan_far_side
  import fan_pkg::*;
#(
  parameter logic [7:0] SHUT_CODE    = 8'h10,
  parameter logic [7:0] RESTART_CODE = 8'h18,
  parameter logic [7:0] OT_CODE      = 8'hc4,
  parameter logic [7:0] HYST_CODE    = 8'h1c
)
(
  input  wire logic [LEVEL_W-1:0] prim,
  input  wire logic [LEVEL_W-1:0] sec,
  input  wire logic [LEVEL_W-1:0] slp,
  input  wire logic               fan_out,
  input  wire logic               fan_oe_n,
  input  wire logic               fault_oe_n,
  output wire logic               shutdown_flag,
  output wire logic               restart_flag,
  output wire logic               overtemp_flag,
  output wire logic               p_below,
  output wire logic               s_below,
  output wire logic               p_wake,
  output wire logic               s_wake,
  output wire logic               fan_pin,
  output wire logic               fault_pin
);
  logic [8:0] wake_lvl;

  assign wake_lvl      = {1'b0, slp} + {1'b0, HYST_CODE};
  assign shutdown_flag = prim < SHUT_CODE;
  assign restart_flag  = prim > RESTART_CODE;
  assign overtemp_flag = prim > OT_CODE;
  assign p_below       = prim < slp;
  assign s_below       = sec < slp;
  assign p_wake        = {1'b0, prim} > wake_lvl;
  assign s_wake        = {1'b0, sec} > wake_lvl;
  // Released fan pin sinks through the transistor base; fault has a pull-up
  assign fan_pin       = fan_oe_n ? 1'b0 : fan_out;
  assign fault_pin     = fault_oe_n ? 1'b1 : 1'b0;
endmodule

`default_nettype wire

// ---- sim/thermal_fan_pwm_controller_tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module thermal_fan_pwm_controller_tb;
  import fan_pkg::*;

  localparam int STEP  = 1;
  localparam int P     = RAMP_STEPS * STEP;
  localparam int LIMIT = 300 * P;

  logic               clk;
  logic               rst;
  logic               ce;
  logic [LEVEL_W-1:0] prim;
  logic [LEVEL_W-1:0] sec;
  logic [LEVEL_W-1:0] slp;
  logic               shutdown_flag;
  logic               restart_flag;
  logic               overtemp_flag;
  logic               p_below;
  logic               s_below;
  logic               p_wake;
  logic               s_wake;
  logic               fan_out;
  logic               fan_oe_n;
  logic               overtemp_fault_n;
  logic               fault_oe_n;
  logic               fan_pin;
  logic               fault_pin;
  int                 fail_count;
  int                 total_checks;
  int                 cyc;
  int                 n;

  fan_ctrl #(.STEP_CYCLES(STEP)) i_fan_ctrl (
    .clk                     (clk),
    .rst                     (rst),
    .ce                      (ce),
    .shutdown_flag           (shutdown_flag),
    .restart_flag            (restart_flag),
    .overtemp_flag           (overtemp_flag),
    .primary_below_sleep     (p_below),
    .secondary_below_sleep   (s_below),
    .primary_above_wake      (p_wake),
    .secondary_above_wake    (s_wake),
    .primary_control_input   (prim),
    .secondary_control_input (sec),
    .fan_out                 (fan_out),
    .fan_oe_n                (fan_oe_n),
    .overtemp_fault_n        (overtemp_fault_n),
    .fault_oe_n              (fault_oe_n)
  );

  fan_far_side i_fan_far_side (
    .prim          (prim),
    .sec           (sec),
    .slp           (slp),
    .fan_out       (fan_out),
    .fan_oe_n      (fan_oe_n),
    .fault_oe_n    (fault_oe_n),
    .shutdown_flag (shutdown_flag),
    .restart_flag  (restart_flag),
    .overtemp_flag (overtemp_flag),
    .p_below       (p_below),
    .s_below       (s_below),
    .p_wake        (p_wake),
    .s_wake        (s_wake),
    .fan_pin       (fan_pin),
    .fault_pin     (fault_pin)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      fail_count++;
      $display("MISMATCH at %0t: timeout", $time);
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic ok, input string what);
    total_checks++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask

  task automatic cycles(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic duty(output int hi);
    hi = 0;
    repeat (P)
    begin
      @(negedge clk);
      hi += (fan_pin === 1'b1);
    end
  endtask

  // Length of the forced-high run after a wake
  task automatic startup_len(output int hi);
    int w;
    w = 0;
    hi = 0;
    while (fan_pin !== 1'b1 && w < 5 * P)
    begin
      @(negedge clk);
      w++;
    end
    while (fan_pin === 1'b1 && hi < 66 * P)
    begin
      @(negedge clk);
      hi++;
    end
  endtask

  function automatic int exp_duty(input int l);
    int d;
    d = 2 * l - 'h9b;
    if (d < 0)
      d = 0;
    if (d > P)
      d = P;
    return d;
  endfunction

  task automatic duty_is(input int l);
    cycles(2 * P);
    duty(n);
    check(n >= exp_duty(l) - 1 && n <= exp_duty(l) + 1, "duty");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    check(fan_out === 1'b0 && fan_oe_n === 1'b0, "fan after reset");
    check(fault_pin === 1'b1, "fault after reset");
    cycles(3 * P);
    check(fan_pin === 1'b0, "fan started below wake");
    $display("test reset done");
  endtask

  task automatic test_wake();
    int lv[3];
    lv = '{'h4d, 'h80, 'hb3};
    prim = 8'ha0;
    startup_len(n);
    check(n >= 64 * P - 2 && n <= 64 * P + P / 2, "startup length");
    foreach (lv[k])
    begin
      prim = lv[k][7:0];
      duty_is(lv[k]);
    end
    prim = 8'h60;
    sec  = 8'h90;
    duty_is('h90);
    prim = 8'h90;
    sec  = 8'h60;
    duty_is('h90);
    $display("test wake done");
  endtask

  task automatic test_overtemp();
    prim = 8'hd0;
    cycles(3 * P);
    check(fault_pin === 1'b0 && overtemp_fault_n === 1'b0, "no fault");
    duty(n);
    check(n == P, "duty in fault");
    prim = 8'h80;
    cycles(3 * P);
    check(fault_pin === 1'b1, "fault stuck");
    $display("test overtemp done");
  endtask

  task automatic test_sleep();
    prim = 8'h20;
    sec  = 8'h20;
    cycles(3 * P);
    check(fan_oe_n === 1'b1 && fault_oe_n === 1'b1, "not asleep");
    prim = 8'h40;
    sec  = 8'h40;
    cycles(3 * P);
    check(fan_oe_n === 1'b1, "woke below wake level");
    sec = 8'h90;
    startup_len(n);
    check(n >= 64 * P - 2 && n <= 64 * P + P / 2, "wake startup");
    $display("test sleep done");
  endtask

  task automatic test_shutdown();
    prim = 8'hd0;
    cycles(3 * P);
    check(fault_pin === 1'b0, "no fault before shutdown");
    prim = 8'h00;
    #1;
    check(fan_oe_n === 1'b1 && fault_oe_n === 1'b1, "shutdown slow");
    cycles(2 * P);
    check(fan_oe_n === 1'b1 && fault_pin === 1'b1, "shutdown left");
    prim = 8'h80;
    startup_len(n);
    check(n >= 64 * P - 2 && n <= 64 * P + P / 2, "restart startup");
    check(fault_pin === 1'b1, "fault kept over restart");
    $display("test shutdown done");
  endtask

  task automatic test_hold();
    logic f;
    slp  = 8'h00;
    prim = 8'h20;
    sec  = 8'h20;
    cycles(3 * P);
    check(fan_oe_n === 1'b0, "slept with sleep disabled");
    prim = 8'h80;
    cycles(P / 2);
    ce = 1'b0;
    f  = fan_out;
    n  = 0;
    repeat (P)
    begin
      @(negedge clk);
      n += (fan_out !== f);
    end
    check(n == 0, "state moved with enable low");
    ce = 1'b1;
    duty_is('h80);
    $display("test hold done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    fail_count   = 0;
    total_checks = 0;
    cyc          = 0;
    rst          = 1'b1;
    ce           = 1'b1;
    prim         = 8'h40;
    sec          = 8'h00;
    slp          = 8'h30;
    cycles(6);
    rst = 1'b0;
    test_reset();
    test_wake();
    test_overtemp();
    test_sleep();
    test_shutdown();
    test_hold();
    end_of_test();
  end
endmodule

`default_nettype wire
